// file: hw/cio_consts.vh
// Purpose: Constants for the configurable I/O port driver.
// Assumes: Included by the design files of the block.
// Notes: Definitions only.
`ifndef CIO_CONSTS_VH
`define CIO_CONSTS_VH
// -----------------------------------------------------------------
// Register byte addresses
// -----------------------------------------------------------------
`define CIO_ADDR_P0_MODE_A 8'h00
`define CIO_ADDR_P0_MODE_B 8'h04
`define CIO_ADDR_P1_MODE_A 8'h08
`define CIO_ADDR_P1_MODE_B 8'h0C
`define CIO_ADDR_P2_MODE_A 8'h10
`define CIO_ADDR_P2_MODE_B 8'h14
`define CIO_ADDR_LATCH0 8'h18
`define CIO_ADDR_LATCH1 8'h1C
`define CIO_ADDR_LATCH2 8'h20
`define CIO_ADDR_PIN0 8'h24
`define CIO_ADDR_PIN1 8'h28
`define CIO_ADDR_PIN2 8'h2C
// -----------------------------------------------------------------
// Field positions and widths
// -----------------------------------------------------------------
`define CIO_NPORT 3
`define CIO_PW 8
`define CIO_NPIN 24
`define CIO_P2_SCHMITT_P2 7
`define CIO_P2_SCHMITT_P1 6
`define CIO_P2_SCHMITT_P0 5
`define CIO_P2_CLKOUT_EN 4
`define CIO_P2_RSVD 3
`define CIO_P2_T0_TOGGLE_EN 2
`define CIO_PIN_P1_OD_A 10
`define CIO_PIN_P1_OD_B 11
`define CIO_PIN_P1_RST 13
`define CIO_PIN_P2_XA 16
`define CIO_PIN_P2_XB 17
// -----------------------------------------------------------------
// Modes, reset values and timing
// -----------------------------------------------------------------
`define CIO_MODE_QUASI 2'b00
`define CIO_MODE_PUSH 2'b01
`define CIO_MODE_INPUT 2'b10
`define CIO_MODE_OPEN 2'b11
`define CIO_REG_RST 8'h00
`define CIO_LATCH_HI 8'hFF
`define CIO_LATCH_LO 8'h00
`define CIO_STRONG_NS 80
`define CIO_CLK_NS 40
`define CIO_STRONG_CYC ((`CIO_STRONG_NS + `CIO_CLK_NS - 1) / `CIO_CLK_NS)
`endif

// file: hw/cio_pin_drv.v
// Purpose: Driver control for one port pin.
// Assumes: Mode, latch and pin level all on the clk domain.
// Notes: Strong pull-up pulse counter is per pin.
`include "cio_consts.vh"
module cio_pin_drv (
  // Clock and reset.
  input wire clk,
  input wire sys_rst,
  // Pin controls.
  input wire [1:0] mode,
  input wire latch,
  input wire pin_level,
  input wire disabled,
  // Driver outputs.
  output reg pu_very_weak_q,
  output reg pu_weak_q,
  output reg pu_strong_q,
  output reg pd_q
);
  reg latch_prev_q;
  reg [1:0] strong_cnt_q;
  wire rise;
  wire quasi;
  wire [31:0] strong_full;
  wire [1:0] strong_len;

  // The pulse length is worked out as a 32-bit count; two bits are enough to hold it.
  assign strong_full = `CIO_STRONG_CYC;
  assign strong_len = strong_full[1:0];
  assign rise = latch & ~latch_prev_q;
  assign quasi = (mode == `CIO_MODE_QUASI);

  // Pulse counter restarts on every zero-to-one latch change while the pin is in quasi mode.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      latch_prev_q <= 1'b0;
      strong_cnt_q <= 2'b00;
    end else begin
      latch_prev_q <= latch;
      if (rise && quasi) begin
        strong_cnt_q <= strong_len - 2'd1;
      end else if (strong_cnt_q != 2'b00) begin
        strong_cnt_q <= strong_cnt_q - 2'd1;
      end
    end
  end

  // Driver controls update on the edge after any change.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pu_very_weak_q <= 1'b0;
      pu_weak_q <= 1'b0;
      pu_strong_q <= 1'b0;
      pd_q <= 1'b0;
    end else if (disabled) begin
      pu_very_weak_q <= 1'b0;
      pu_weak_q <= 1'b0;
      pu_strong_q <= 1'b0;
      pd_q <= 1'b0;
    end else begin
      pu_very_weak_q <= quasi & latch;
      pu_weak_q <= quasi & latch & pin_level;
      pu_strong_q <= (quasi & rise) | (quasi & latch & (strong_cnt_q != 2'b00))
                   | ((mode == `CIO_MODE_PUSH) & latch);
      pd_q <= (mode != `CIO_MODE_INPUT) & ~latch;
    end
  end
endmodule // cio_pin_drv

// file: hw/cio_port_top.v
// Purpose: Three-port configurable I/O driver with an AHB-Lite register slave.
// Assumes: Single 25 MHz clock; pad level arrives asynchronously.
// Notes: Driver controls are registered; pads resolve them outside.
`include "cio_consts.vh"
module cio_port_top (
  // Clock and reset.
  input wire clk,
  input wire sys_rst,
  // Configuration straps.
  input wire port_reset_level_high,
  input wire crystal_osc_sel,
  input wire internal_reset_sel,
  input wire rc_or_ext_clk_sel,
  // AHB-Lite slave.
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Pads.
  input wire [23:0] pad_in,
  output wire [23:0] pu_very_weak,
  output wire [23:0] pu_weak,
  output wire [23:0] pu_strong,
  output wire [23:0] pull_down,
  output wire [23:0] schmitt_en,
  output wire [23:0] input_en,
  // Side functions.
  output wire t0_toggle_out_en,
  output wire clk_out_en
);
  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  reg [7:0] mode_a_q [0:2];
  reg [7:0] mode_b_q [0:2];
  reg [7:0] latch_q [0:2];
  reg [23:0] sync1_q, sync2_q, sync3_q, pin_q;
  reg [31:0] rdata_q;
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  reg rst_hi_q;
  reg rst_seen_q;
  wire [7:0] p2_a;
  wire addr_ok;
  integer i;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign p2_a = mode_a_q[2];
  assign t0_toggle_out_en = p2_a[`CIO_P2_T0_TOGGLE_EN];
  assign clk_out_en = p2_a[`CIO_P2_CLKOUT_EN] & rc_or_ext_clk_sel;

  // Pad input: three flops, accepted once stages two and three agree.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= 24'h0000_00;
      sync2_q <= 24'h0000_00;
      sync3_q <= 24'h0000_00;
      pin_q <= 24'h0000_00;
    end else begin
      sync1_q <= pad_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (i = 0; i < `CIO_NPIN; i = i + 1) begin
        if (sync2_q[i] == sync3_q[i]) begin
          pin_q[i] <= sync3_q[i];
        end
      end
    end
  end

  // Reset level strap is caught by a clocked process after release.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_seen_q <= 1'b0;
      rst_hi_q <= 1'b0;
    end else if (!rst_seen_q) begin
      rst_seen_q <= 1'b1;
      rst_hi_q <= port_reset_level_high;
    end
  end

  // -----------------------------------------------------------------
  // AHB-Lite register slave
  // -----------------------------------------------------------------
  // Zero wait states: writes land at the data phase edge, reads answer there.
  assign addr_ok = (haddr[7:0] <= `CIO_ADDR_PIN2) && (haddr[1:0] == 2'b00);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= 1'b0;
      if (hsel && hready && htrans[1]) begin
        wr_pend_q <= hwrite;
        wr_addr_q <= haddr[7:0];
        rdata_q <= 32'h0000_0000;
        if (!hwrite && addr_ok) begin
          case (haddr[7:0])
            `CIO_ADDR_P0_MODE_A: rdata_q[7:0] <= mode_a_q[0];
            `CIO_ADDR_P0_MODE_B: rdata_q[7:0] <= mode_b_q[0];
            `CIO_ADDR_P1_MODE_A: rdata_q[7:0] <= mode_a_q[1];
            `CIO_ADDR_P1_MODE_B: rdata_q[7:0] <= mode_b_q[1];
            `CIO_ADDR_P2_MODE_A: rdata_q[7:0] <= mode_a_q[2];
            `CIO_ADDR_P2_MODE_B: rdata_q[7:0] <= mode_b_q[2];
            `CIO_ADDR_LATCH0: rdata_q[7:0] <= latch_q[0];
            `CIO_ADDR_LATCH1: rdata_q[7:0] <= latch_q[1];
            `CIO_ADDR_LATCH2: rdata_q[7:0] <= latch_q[2];
            `CIO_ADDR_PIN0: rdata_q[7:0] <= pin_q[7:0] & input_en[7:0];
            `CIO_ADDR_PIN1: rdata_q[7:0] <= pin_q[15:8] & input_en[15:8];
            `CIO_ADDR_PIN2: rdata_q[7:0] <= pin_q[23:16] & input_en[23:16];
            default: rdata_q <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // Register writes; reset gives quasi mode and low latches, and the strapped latch level is loaded on the first edge after release.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (i = 0; i < `CIO_NPORT; i = i + 1) begin
        mode_a_q[i] <= `CIO_REG_RST;
        mode_b_q[i] <= `CIO_REG_RST;
        latch_q[i] <= `CIO_LATCH_LO;
      end
    end else if (!rst_seen_q) begin
      for (i = 0; i < `CIO_NPORT; i = i + 1) begin
        latch_q[i] <= port_reset_level_high ? `CIO_LATCH_HI : `CIO_LATCH_LO;
      end
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        `CIO_ADDR_P0_MODE_A: mode_a_q[0] <= hwdata[7:0];
        `CIO_ADDR_P0_MODE_B: mode_b_q[0] <= hwdata[7:0];
        `CIO_ADDR_P1_MODE_A: mode_a_q[1] <= hwdata[7:0];
        `CIO_ADDR_P1_MODE_B: mode_b_q[1] <= hwdata[7:0];
        `CIO_ADDR_P2_MODE_A: begin
          mode_a_q[2] <= hwdata[7:0];
          mode_a_q[2][`CIO_P2_RSVD] <= 1'b0;
        end
        `CIO_ADDR_P2_MODE_B: mode_b_q[2] <= hwdata[7:0];
        `CIO_ADDR_LATCH0: latch_q[0] <= hwdata[7:0];
        `CIO_ADDR_LATCH1: latch_q[1] <= hwdata[7:0];
        `CIO_ADDR_LATCH2: latch_q[2] <= hwdata[7:0];
        default: latch_q[0] <= latch_q[0];
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Per-pin drivers
  // -----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `CIO_NPIN; g = g + 1) begin : g_pin
      wire fixed_od;
      wire rst_pin;
      wire xtal_pin;
      wire [1:0] pin_mode;
      wire [7:0] ma;
      wire [7:0] mb;
      wire [7:0] lt;
      wire [7:0] sch;
      assign ma = mode_a_q[g / `CIO_PW];
      assign mb = mode_b_q[g / `CIO_PW];
      assign lt = latch_q[g / `CIO_PW];
      assign sch = {5'b00000, p2_a[`CIO_P2_SCHMITT_P2], p2_a[`CIO_P2_SCHMITT_P1],
                    p2_a[`CIO_P2_SCHMITT_P0]};
      assign fixed_od = (g == `CIO_PIN_P1_OD_A) || (g == `CIO_PIN_P1_OD_B);
      assign rst_pin = (g == `CIO_PIN_P1_RST);
      assign xtal_pin = (g == `CIO_PIN_P2_XA) || (g == `CIO_PIN_P2_XB);
      // Fixed pins override mode bits; the reset pin never drives.
      assign pin_mode = fixed_od ? `CIO_MODE_OPEN :
                        rst_pin ? `CIO_MODE_INPUT :
                        {ma[g % `CIO_PW], mb[g % `CIO_PW]};
      // Reset pin only reads when reset is internal; crystal pins do not read while crystal_osc_sel is set.
      assign input_en[g] = ~(xtal_pin & crystal_osc_sel) &
                           ~(rst_pin & ~internal_reset_sel);
      assign schmitt_en[g] = fixed_od | rst_pin | sch[g / `CIO_PW];

      cio_pin_drv u_drv (
        .clk(clk),
        .sys_rst(sys_rst),
        .mode(pin_mode),
        .latch(lt[g % `CIO_PW]),
        .pin_level(pin_q[g]),
        .disabled(xtal_pin & crystal_osc_sel),
        .pu_very_weak_q(pu_very_weak[g]),
        .pu_weak_q(pu_weak[g]),
        .pu_strong_q(pu_strong[g]),
        .pd_q(pull_down[g])
      );
    end
  endgenerate
endmodule // cio_port_top

// file: tb/cio_port_props.sv
// Purpose: Port-level assertions for the configurable I/O port driver.
// Assumes: Bound into cio_port_top; one clock domain.
// Notes: Mode registers are not visible here, so only mode-free relations are asserted.
module cio_port_props (
  // Clock and reset.
  input wire clk,
  input wire sys_rst,
  // Straps and bus.
  input wire crystal_osc_sel,
  input wire internal_reset_sel,
  input wire rc_or_ext_clk_sel,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  // Pad controls.
  input wire [23:0] pu_very_weak,
  input wire [23:0] pu_weak,
  input wire [23:0] pu_strong,
  input wire [23:0] pull_down,
  input wire [23:0] schmitt_en,
  input wire [23:0] input_en,
  input wire clk_out_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // A pin never pulls both ways, whatever its mode.
  a_no_drive_fight: assert property ((pull_down & (pu_very_weak | pu_weak | pu_strong)) == 24'h0)
    else $error("pull-up and pull-down on together");
  a_weak_needs_vweak: assert property ((pu_weak & ~pu_very_weak) == 24'h0)
    else $error("weak pull-up without very weak pull-up");
  a_fixed_od_pins: assert property ((pu_very_weak[11:10] | pu_weak[11:10] | pu_strong[11:10]) == 2'b00)
    else $error("fixed open drain pin drives high");
  a_reset_pin_input: assert property ({pu_very_weak[13], pu_weak[13], pu_strong[13], pull_down[13]} == 4'h0
    && input_en[13] == internal_reset_sel)
    else $error("shared reset pin is not a plain input");
  a_fixed_schmitt: assert property (schmitt_en[10] && schmitt_en[11] && schmitt_en[13])
    else $error("fixed pin lost its schmitt input");
  // The strap reaches the registered drivers one edge late, hence the past term.
  a_xtal_pins_off: assert property (crystal_osc_sel && $past(crystal_osc_sel) |-> input_en[17:16] == 2'b00
    && (pu_very_weak[17:16] | pu_weak[17:16] | pu_strong[17:16] | pull_down[17:16]) == 2'b00)
    else $error("crystal pins still active");
  a_clkout_gated: assert property (clk_out_en |-> rc_or_ext_clk_sel)
    else $error("clock output without rc or external clock");
  a_read_upper_zero: assert property (hsel && hready && htrans[1] && !hwrite |=> hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
endmodule // cio_port_props

bind cio_port_top cio_port_props u_props (.clk(clk), .sys_rst(sys_rst),
  .crystal_osc_sel(crystal_osc_sel), .internal_reset_sel(internal_reset_sel),
  .rc_or_ext_clk_sel(rc_or_ext_clk_sel), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .pu_very_weak(pu_very_weak), .pu_weak(pu_weak),
  .pu_strong(pu_strong), .pull_down(pull_down), .schmitt_en(schmitt_en), .input_en(input_en),
  .clk_out_en(clk_out_en));

// file: tb/cio_pad_model.sv
// Purpose: Outside circuitry on the 24 pads.
// Assumes: Every pad has a system pull-up; the bench names pads held low outside.
// Notes: A pad released by everyone reads high through the pull-up.
module cio_pad_model (
  // Drive from the port block and the outside world.
  input wire logic [23:0] pull_down,
  input wire logic [23:0] ext_low,
  // Resolved levels.
  output logic [23:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Any low driver wins over the system pull-up, which open drain outputs rely on.
  assign pad_in = ~(pull_down | ext_low);
endmodule // cio_pad_model

// file: tb/configurable_io_port_driver_bench.sv
// Purpose: Self-checking bench for cio_port_top.
// Assumes: 25 MHz clock, AHB-Lite master with zero wait state slave.
// Notes: Push-pull pins are only checked for strong pull-up and pull-down.
`include "cio_consts.vh"
module configurable_io_port_driver_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, sys_rst = 1, strap = 1, xtal = 0, intr = 1, rc = 0, hsel = 0, hwrite = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd;
  logic [23:0] ext = 24'h00_0000, es;
  logic [7:0] ma[3], mb[3], lat[3];
  wire [31:0] hrdata;
  wire hreadyout, hresp, t0_en, ck_en;
  wire [23:0] pad, vw, w, s, pd, sch, ien;
  int err_total = 0, num_checks = 0, c;
  // Clock at 40 ns.
  always #20 clk = ~clk;
  cio_port_top dut (.clk(clk), .sys_rst(sys_rst), .port_reset_level_high(strap),
    .crystal_osc_sel(xtal), .internal_reset_sel(intr), .rc_or_ext_clk_sel(rc), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pad_in(pad),
    .pu_very_weak(vw), .pu_weak(w), .pu_strong(s), .pull_down(pd), .schmitt_en(sch),
    .input_en(ien), .t0_toggle_out_en(t0_en), .clk_out_en(ck_en));
  cio_pad_model pads (.pull_down(pd), .ext_low(ext), .pad_in(pad));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One single word transfer; read data is taken at the end of the data phase.
  task automatic bus(logic wr, logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  // Steady driver state {very weak, weak, strong, pull-down} of pin n.
  function automatic logic [3:0] expd(int n);
    logic [1:0] m;
    logic l;
    m = {ma[n/8][n%8], mb[n/8][n%8]};
    l = lat[n/8][n%8];
    if (n == 10 || n == 11) m = 2'b11;
    if (n == 13 || (xtal && (n == 16 || n == 17)) || m == 2'b10) return 4'h0;
    if (m == 2'b11) return {3'b000, ~l};
    if (m == 2'b01) return {2'b00, l, ~l};
    return {l, l & ~ext[n], 1'b0, ~l};
  endfunction
  // Expected pin level register of port p: pad level from the outside model, masked by readability.
  function automatic logic [7:0] pinx(int p);
    logic [7:0] v;
    logic [3:0] e;
    int n;
    for (int b = 0; b < 8; b++) begin
      n = 8 * p + b;
      e = expd(n);
      v[b] = ~(e[0] | ext[n]) & ~(xtal && (n == 16 || n == 17)) & ~(n == 13 && !intr);
    end
    return v;
  endfunction
  task automatic pins;
    logic [3:0] k;
    @(negedge clk);
    for (int n = 0; n < 24; n++) begin
      k = ({ma[n/8][n%8], mb[n/8][n%8]} == 2'b01 && n != 10 && n != 11) ? 4'h3 : 4'hf;
      chk("drivers", expd(n) & k, {vw[n], w[n], s[n], pd[n]} & k);
    end
  endtask
  task automatic do_reset(logic hi);
    sys_rst <= 1'b1;
    strap <= hi;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    for (int p = 0; p < 3; p++) begin
      ma[p] = 8'h00;
      mb[p] = 8'h00;
      lat[p] = hi ? 8'hff : 8'h00;
    end
    repeat (10) @(posedge clk);
    pins;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests take.
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_sim;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h9b07_0274));
    do_reset(1'b1);
    // Random modes, latches, straps and outside loads, read back afterwards.
    for (int i = 0; i < 6; i++) begin
      xtal <= $urandom;
      rc <= $urandom;
      intr <= $urandom;
      ext <= $urandom;
      for (int p = 0; p < 3; p++) begin
        ma[p] = $urandom;
        mb[p] = $urandom;
        lat[p] = $urandom;
        bus(1'b1, 8 * p, ma[p]);
        bus(1'b1, 8 * p + 4, mb[p]);
        bus(1'b1, `CIO_ADDR_LATCH0 + 4 * p, lat[p]);
      end
      ma[2][3] = 1'b0;
      repeat (10) @(posedge clk);
      pins;
      es = {{8{ma[2][7]}}, {8{ma[2][6]}}, {8{ma[2][5]}}} | 24'h00_2c00;
      chk("schmitt", {8'h00, es}, {8'h00, sch});
      chk("side enables", {30'h0, ma[2][2], ma[2][4] & rc}, {30'h0, t0_en, ck_en});
      for (int p = 0; p < 3; p++) begin
        bus(1'b0, 8 * p, 8'h00);
        chk("mode a", {24'h00_0000, ma[p]}, rd);
        bus(1'b0, 8 * p + 4, 8'h00);
        chk("mode b", {24'h00_0000, mb[p]}, rd);
        bus(1'b0, `CIO_ADDR_LATCH0 + 4 * p, 8'h00);
        chk("latch", {24'h00_0000, lat[p]}, rd);
        bus(1'b0, `CIO_ADDR_PIN0 + 4 * p, 8'h00);
        chk("pin level", {24'h00_0000, pinx(p)}, rd);
      end
    end
    // Strong pulse on a quasi pin, twice in a row to see it restart.
    ext <= 24'h00_0000;
    ma[0] = 8'h00;
    mb[0] = 8'h00;
    bus(1'b1, `CIO_ADDR_P0_MODE_A, 8'h00);
    bus(1'b1, `CIO_ADDR_P0_MODE_B, 8'h00);
    for (int r = 0; r < 2; r++) begin
      bus(1'b1, `CIO_ADDR_LATCH0, 8'h00);
      bus(1'b1, `CIO_ADDR_LATCH0, 8'hff);
      c = 0;
      repeat (8) begin
        @(negedge clk);
        c += s[0];
      end
      chk("strong pulse cycles", 32'd2, c);
    end
    bus(1'b0, 8'h40, 8'h00);
    chk("unmapped read", 32'h0000_0000, rd);
    do_reset(1'b0);
    end_sim;
  end
endmodule // configurable_io_port_driver_bench
